// ---- raw_fmt_pkg.sv ----
// How it works
// - word 0 of a block is tag 00, marker 10010 and trigger number bits 26 to 16.
// - word 1 is tag 00 and trigger number bits 15 to 0.
// - word 2 is tag 00, marker 10011000 and time stamp bits 47 to 40.
// - word 3 is tag 00 and time stamp bits 39 to 24.
// - word 4 is a tag, eight zero bits and time stamp bits 23 to 16, tagged 00 when there is an event.
// - word 5 is a tag and time stamp bits 15 to 0, tagged 00 when there is an event.
// - with an event, words from location 6 on are the window samples in order, tagged 00, untouched.
// - the block closes at location N+7 with tag 11 and payload FFFF, N being the window length.
// - without an event, words 4 and 5 carry tag 01 instead of 00.
// - without an event, words from location 6 on are fillers of tag 01 and payload 0000.
package raw_fmt_pkg;

    // ********************************
    // widths
    // ********************************
    localparam int TAG_W = 2;
    localparam int PAY_W = 16;
    localparam int TRIG_W = 27;
    localparam int TS_W = 48;
    localparam int HEAD_LOC_W = 3;

    // ********************************
    // tags, markers and fixed payloads
    // ********************************
    localparam logic [1:0] TAG_DATA = 2'h0;
    localparam logic [1:0] TAG_NO_EVENT = 2'h1;
    localparam logic [1:0] TAG_END = 2'h3;
    localparam logic [4:0] TRIG_MARK = 5'h12;
    localparam logic [7:0] TS_MARK = 8'h98;
    localparam logic [7:0] TS_LOW_PAD = 8'h00;
    localparam logic [15:0] END_PAYLOAD = 16'hFFFF;
    localparam logic [15:0] FILL_PAYLOAD = 16'h0000;

    // ********************************
    // header locations
    // ********************************
    localparam logic [2:0] LOC_TRIG_HI = 3'h0;
    localparam logic [2:0] LOC_TRIG_LO = 3'h1;
    localparam logic [2:0] LOC_TS_TOP = 3'h2;
    localparam logic [2:0] LOC_TS_MID = 3'h3;
    localparam logic [2:0] LOC_TS_LOW = 3'h4;
    localparam logic [2:0] LOC_TS_BOT = 3'h5;

    // ********************************
    // carriers and states
    // ********************************
    typedef struct packed {
        logic [TAG_W-1:0] tag;
        logic [PAY_W-1:0] payload;
    } word_s;

    typedef struct packed {
        logic [TRIG_W-1:0] trig_num;
        logic [TS_W-1:0] time_stamp;
        logic has_event;
    } trig_info_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HEAD = 2'b01,
        ST_BODY = 2'b10,
        ST_TAIL = 2'b11
    } fmt_state_e;

endpackage : raw_fmt_pkg

// ---- header_word_mux.sv ----
`timescale 1ns/1ns
`default_nettype none
module header_word_mux
    import raw_fmt_pkg::*;
(
    input wire logic [HEAD_LOC_W-1:0] loc_i,
    input wire trig_info_s info_i,
    output word_s word_o
);

    logic [TAG_W-1:0] low_tag;

    // low time stamp words flag a channel without an event
    assign low_tag = info_i.has_event ? TAG_DATA : TAG_NO_EVENT;

    // pick the header word for this location
    always_comb begin
        unique case (loc_i)
            LOC_TRIG_HI: word_o = '{TAG_DATA, {TRIG_MARK, info_i.trig_num[26:16]}};
            LOC_TRIG_LO: word_o = '{TAG_DATA, info_i.trig_num[15:0]};
            LOC_TS_TOP: word_o = '{TAG_DATA, {TS_MARK, info_i.time_stamp[47:40]}};
            LOC_TS_MID: word_o = '{TAG_DATA, info_i.time_stamp[39:24]};
            LOC_TS_LOW: word_o = '{low_tag, {TS_LOW_PAD, info_i.time_stamp[23:16]}};
            LOC_TS_BOT: word_o = '{low_tag, info_i.time_stamp[15:0]};
            // code 6 reaches here after word 5 and stays through the body, where this word goes unused; code 7 never does
            default: word_o = '{TAG_DATA, FILL_PAYLOAD};
        endcase
    end

endmodule : header_word_mux
`default_nettype wire

// ---- raw_mode_event_formatter.sv ----
`timescale 1ns/1ns
`default_nettype none
module raw_mode_event_formatter
    import raw_fmt_pkg::*;
#(
    parameter int LEN_W = 12,
    parameter int SAMPLE_W = 12,
    parameter int LOC_W = LEN_W + 1
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic start_i,
    input wire trig_info_s info_i,
    input wire logic [LEN_W-1:0] trigger_window_length_i,
    output logic start_ready_o,
    input wire logic sample_valid_i,
    input wire logic [SAMPLE_W-1:0] sample_i,
    output logic sample_ready_o,
    output logic word_valid_o,
    output word_s word_o,
    output logic [LOC_W-1:0] word_loc_o,
    output logic block_done_o
);

    // ********************************
    // local sizes
    // ********************************
    // samples are zero-extended into the payload
    localparam int PAD_W = PAY_W - SAMPLE_W;

    // ********************************
    // state
    // ********************************
    fmt_state_e state_r;
    fmt_state_e state_nxt;
    trig_info_s info_r;
    trig_info_s info_nxt;
    logic [LEN_W-1:0] len_r;
    logic [LEN_W-1:0] len_nxt;
    logic [HEAD_LOC_W-1:0] head_loc_r;
    logic [HEAD_LOC_W-1:0] head_loc_nxt;
    // one bit wider than the length, so N+1 body words still count at the top length
    logic [LEN_W:0] body_cnt_r;
    logic [LEN_W:0] body_cnt_nxt;
    logic [LOC_W-1:0] loc_r;
    logic [LOC_W-1:0] loc_nxt;

    // ********************************
    // registered outputs
    // ********************************
    logic start_ready_r;
    logic start_ready_nxt;
    logic sample_ready_r;
    logic sample_ready_nxt;
    logic word_valid_r;
    logic word_valid_nxt;
    word_s word_r;
    word_s word_nxt;
    logic [LOC_W-1:0] word_loc_r;
    logic [LOC_W-1:0] word_loc_nxt;
    logic block_done_r;
    logic block_done_nxt;

    // ********************************
    // helpers
    // ********************************
    word_s head_word;
    word_s body_word;
    logic sample_take;
    logic body_fire;
    logic body_last;

    // header words come from a small lookup on the captured trigger info
    header_word_mux u_head (
        .loc_i(head_loc_r),
        .info_i(info_r),
        .word_o(head_word)
    );

    // a sample is only consumed while ready is up, so none is dropped
    assign sample_take = sample_valid_i && sample_ready_r;
    // fillers need no source, one goes out every cycle
    assign body_fire = info_r.has_event ? sample_take : 1'b1;
    // the body holds samples 0 to N, so the end marker lands at N+7
    assign body_last = (body_cnt_r == {1'b0, len_r});

    // body word: raw sample with event, filler without
    always_comb begin
        if (info_r.has_event) begin
            word_nxt_sel_sample: begin
                body_word = '{TAG_DATA, {{PAD_W{1'b0}}, sample_i}};
            end
        end else begin
            body_word = '{TAG_NO_EVENT, FILL_PAYLOAD};
        end
    end

    // ********************************
    // framer sequencing
    // ********************************
    // next state; the location counter is cleared on start and steps up by one per header and body word
    always_comb begin
        state_nxt = state_r;
        info_nxt = info_r;
        len_nxt = len_r;
        head_loc_nxt = head_loc_r;
        body_cnt_nxt = body_cnt_r;
        loc_nxt = loc_r;
        word_valid_nxt = 1'b0;
        word_nxt = word_r;
        word_loc_nxt = word_loc_r;
        block_done_nxt = 1'b0;
        unique case (state_r)
            ST_IDLE: begin
                // trigger info and window length are frozen for the whole block
                if (start_i) begin
                    info_nxt = info_i;
                    len_nxt = trigger_window_length_i;
                    head_loc_nxt = LOC_TRIG_HI;
                    loc_nxt = '0;
                    state_nxt = ST_HEAD;
                end
            end
            ST_HEAD: begin
                // six header words, locations 0 to 5
                word_valid_nxt = 1'b1;
                word_nxt = head_word;
                word_loc_nxt = loc_r;
                loc_nxt = loc_r + 1'b1;
                head_loc_nxt = head_loc_r + 1'b1;
                if (head_loc_r == LOC_TS_BOT) begin
                    body_cnt_nxt = '0;
                    state_nxt = ST_BODY;
                end
            end
            ST_BODY: begin
                // with an event each word waits for a sample, fillers go every cycle
                if (body_fire) begin
                    word_valid_nxt = 1'b1;
                    word_nxt = body_word;
                    word_loc_nxt = loc_r;
                    loc_nxt = loc_r + 1'b1;
                    body_cnt_nxt = body_cnt_r + 1'b1;
                    if (body_last) begin
                        state_nxt = ST_TAIL;
                    end
                end
            end
            ST_TAIL: begin
                // location not stepped here, the next start clears it anyway
                word_valid_nxt = 1'b1;
                word_nxt = '{TAG_END, END_PAYLOAD};
                word_loc_nxt = loc_r;
                block_done_nxt = 1'b1;
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ********************************
    // handshake flags
    // ********************************
    // handshake flags follow the state that comes next, so they sit on flops
    always_comb begin
        start_ready_nxt = (state_nxt == ST_IDLE);
        sample_ready_nxt = (state_nxt == ST_BODY) && info_nxt.has_event;
    end

    // handshake flags reset low, so nothing is offered while reset is held
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            start_ready_r <= 1'b0;
            sample_ready_r <= 1'b0;
        end else begin
            start_ready_r <= start_ready_nxt;
            sample_ready_r <= sample_ready_nxt;
        end
    end

    // ********************************
    // framer registers
    // ********************************
    // framer group; control state has a fixed value under reset
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= ST_IDLE;
            info_r <= '0;
            len_r <= '0;
            head_loc_r <= '0;
            body_cnt_r <= '0;
            loc_r <= '0;
            word_valid_r <= 1'b0;
            word_r <= '0;
            word_loc_r <= '0;
            block_done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            info_r <= info_nxt;
            len_r <= len_nxt;
            head_loc_r <= head_loc_nxt;
            body_cnt_r <= body_cnt_nxt;
            loc_r <= loc_nxt;
            word_valid_r <= word_valid_nxt;
            word_r <= word_nxt;
            word_loc_r <= word_loc_nxt;
            block_done_r <= block_done_nxt;
        end
    end

    // ********************************
    // outputs
    // ********************************
    // all straight from flops; the reader has no stall, it must take every word
    assign start_ready_o = start_ready_r;
    assign sample_ready_o = sample_ready_r;
    assign word_valid_o = word_valid_r;
    assign word_o = word_r;
    assign word_loc_o = word_loc_r;
    assign block_done_o = block_done_r;

endmodule : raw_mode_event_formatter
`default_nettype wire

// ---- raw_fmt_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module raw_fmt_monitor
    import raw_fmt_pkg::*;
#(
    parameter int LEN_W = 12,
    parameter int SAMPLE_W = 12,
    parameter int LOC_W = LEN_W + 1
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic start_i,
    input wire trig_info_s info_i,
    input wire logic [LEN_W-1:0] trigger_window_length_i,
    input wire logic start_ready_o,
    input wire logic sample_valid_i,
    input wire logic [SAMPLE_W-1:0] sample_i,
    input wire logic sample_ready_o,
    input wire logic word_valid_o,
    input wire word_s word_o,
    input wire logic [LOC_W-1:0] word_loc_o,
    input wire logic block_done_o
);
    trig_info_s inf_r;
    logic [LEN_W-1:0] len_r;
    logic [LOC_W-1:0] last_r;
    logic fresh_r;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    // copy taken only on an accepted start; the framer is idle at the first edge after reset
    // although ready is still low there, so that edge takes a start as well
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            inf_r <= '0;
            len_r <= '0;
            last_r <= '0;
            fresh_r <= 1'b1;
        end else begin
            fresh_r <= 1'b0;
            if (start_i && (start_ready_o || fresh_r)) begin
                inf_r <= info_i;
                len_r <= trigger_window_length_i;
            end
            if (word_valid_o) begin
                last_r <= word_loc_o;
            end
        end
    end
    property p_trig_hi; word_valid_o && word_loc_o == 0 |-> word_o == {TAG_DATA, TRIG_MARK, inf_r.trig_num[26:16]};
    endproperty
    a_trig_hi: assert property (p_trig_hi) else $error("bad word 0");
    property p_trig_lo; word_valid_o && word_loc_o == 1 |-> word_o == {TAG_DATA, inf_r.trig_num[15:0]};
    endproperty
    a_trig_lo: assert property (p_trig_lo) else $error("bad word 1");
    property p_ts_top; word_valid_o && word_loc_o == 2 |-> word_o == {TAG_DATA, TS_MARK, inf_r.time_stamp[47:40]};
    endproperty
    a_ts_top: assert property (p_ts_top) else $error("bad word 2");
    property p_ts_mid; word_valid_o && word_loc_o == 3 |-> word_o == {TAG_DATA, inf_r.time_stamp[39:24]};
    endproperty
    a_ts_mid: assert property (p_ts_mid) else $error("bad word 3");
    property p_ts_low; word_valid_o && word_loc_o == 4 |-> word_o == {!inf_r.has_event ? TAG_NO_EVENT : TAG_DATA,
        TS_LOW_PAD, inf_r.time_stamp[23:16]};
    endproperty
    a_ts_low: assert property (p_ts_low) else $error("bad word 4 tag");
    property p_ts_bot; word_valid_o && word_loc_o == 5 |-> word_o == {!inf_r.has_event ? TAG_NO_EVENT : TAG_DATA,
        inf_r.time_stamp[15:0]};
    endproperty
    a_ts_bot: assert property (p_ts_bot) else $error("bad word 5");
    property p_samp; sample_valid_i && sample_ready_o |=> word_valid_o && word_o == {TAG_DATA, 16'($past(sample_i))};
    endproperty
    a_samp: assert property (p_samp) else $error("sample word wrong");
    property p_fill; word_valid_o && !inf_r.has_event && word_loc_o > 5 && !block_done_o |->
        word_o == {TAG_NO_EVENT, FILL_PAYLOAD};
    endproperty
    a_fill: assert property (p_fill) else $error("filler wrong");
    property p_end; block_done_o |-> word_valid_o && word_o == {TAG_END, END_PAYLOAD} && word_loc_o == len_r + 7;
    endproperty
    a_end: assert property (p_end) else $error("end word wrong");
    property p_asc; word_valid_o && word_loc_o != 0 |-> word_loc_o == LOC_W'(last_r + 1'b1);
    endproperty
    a_asc: assert property (p_asc) else $error("location skipped");
    c_event: cover property (block_done_o && inf_r.has_event);
    c_empty: cover property (block_done_o && !inf_r.has_event);
    c_len0: cover property (block_done_o && len_r == 0);
endmodule : raw_fmt_monitor
bind raw_mode_event_formatter raw_fmt_monitor #(.LEN_W(LEN_W), .SAMPLE_W(SAMPLE_W), .LOC_W(LOC_W)) i_mon (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .start_i(start_i), .info_i(info_i),
    .trigger_window_length_i(trigger_window_length_i), .start_ready_o(start_ready_o),
    .sample_valid_i(sample_valid_i), .sample_i(sample_i), .sample_ready_o(sample_ready_o),
    .word_valid_o(word_valid_o), .word_o(word_o), .word_loc_o(word_loc_o), .block_done_o(block_done_o));
`default_nettype wire

// ---- word_sink.sv ----
`timescale 1ns/1ns
`default_nettype none
module word_sink
    import raw_fmt_pkg::*;
#(
    parameter int LOC_W = 13
) (
    input wire logic clock_i,
    input wire logic word_valid_i,
    input wire word_s word_i,
    input wire logic [LOC_W-1:0] word_loc_i
);
    word_s got[$];
    logic [LOC_W-1:0] locs[$];
    // caught mid-cycle where the words have settled; the reader has no back-pressure
    always @(negedge clock_i) begin
        if (word_valid_i) begin
            got.push_back(word_i);
            locs.push_back(word_loc_i);
        end
    end
endmodule : word_sink
`default_nettype wire

// ---- raw_mode_event_formatter_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; $display("[ERR] %0t mismatch", $time); end end
module raw_mode_event_formatter_bench
    import raw_fmt_pkg::*;
;
    logic clock_i = 1'b0, rst_b_i = 1'b0, start_i = 1'b0, sample_valid_i = 1'b0;
    trig_info_s info_i = '0;
    logic [11:0] trigger_window_length_i = '0, sample_i = '0;
    logic start_ready_o, sample_ready_o, word_valid_o, block_done_o;
    word_s word_o;
    logic [12:0] word_loc_o;
    int mismatches = 0, cmp_count = 0, cycles = 0;
    always #5 clock_i = ~clock_i;
    raw_mode_event_formatter i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .start_i(start_i), .info_i(info_i),
        .trigger_window_length_i(trigger_window_length_i), .start_ready_o(start_ready_o),
        .sample_valid_i(sample_valid_i), .sample_i(sample_i), .sample_ready_o(sample_ready_o),
        .word_valid_o(word_valid_o), .word_o(word_o), .word_loc_o(word_loc_o), .block_done_o(block_done_o));
    word_sink i_sink (.clock_i(clock_i), .word_valid_i(word_valid_o), .word_i(word_o), .word_loc_i(word_loc_o));
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    function automatic word_s exp_w(input logic ev, input logic [26:0] tn, input logic [47:0] ts, input int j,
        input int n);
        logic [1:0] lt;
        lt = ev ? 2'h0 : 2'h1;
        case (j)
            0: return {2'h0, 5'h12, tn[26:16]};
            1: return {2'h0, tn[15:0]};
            2: return {2'h0, 8'h98, ts[47:40]};
            3: return {2'h0, ts[39:24]};
            4: return {lt, 8'h00, ts[23:16]};
            5: return {lt, ts[15:0]};
            default: return (j > n + 6) ? {2'h3, 16'hFFFF} : ev ? {2'h0, 16'(12'hA50 + 12'(j - 6))} : {2'h1, 16'h0000};
        endcase
    endfunction : exp_w
    // one block; a stray start mid-block must be ignored, gaps stall the samples
    task automatic run_block(input logic ev, input logic [26:0] tn, input logic [47:0] ts, input int n, input int gap);
        int k;
        int w;
        k = 0;
        w = 0;
        while (start_ready_o !== 1'b1) @(negedge clock_i);
        i_sink.got.delete();
        i_sink.locs.delete();
        start_i = 1'b1;
        info_i = {tn, ts, ev};
        trigger_window_length_i = 12'(n);
        while (block_done_o !== 1'b1) begin
            @(negedge clock_i);
            w++;
            start_i = (w == 3);
            // new info on the stray start, so a wrongly taken one shows in the header
            if (w == 3) info_i = ~info_i;
            if (w == 1) `CHK(start_ready_o, 1'b0)
            sample_valid_i = ev && k <= n && (gap == 0 || w % 2 == 0);
            sample_i = 12'hA50 + 12'(k);
            if (sample_valid_i && sample_ready_o) k++;
        end
        @(negedge clock_i);
        sample_valid_i = 1'b0;
        `CHK(start_ready_o, 1'b1)
        `CHK(block_done_o, 1'b0)
        `CHK(i_sink.got.size(), n + 8)
        for (int j = 0; j < i_sink.got.size(); j++) begin
            `CHK(i_sink.locs[j], 13'(j))
            `CHK(i_sink.got[j], exp_w(ev, tn, ts, j, n))
        end
    endtask : run_block
    task automatic t_event_gaps();
        run_block(1'b1, 27'h4ABCDEF, 48'h9876_5432_10FE, 3, 1);
    endtask : t_event_gaps
    task automatic t_no_event();
        run_block(1'b0, 27'h0123456, 48'hFEDC_BA98_7654, 1, 0);
    endtask : t_no_event
    task automatic t_zero_len();
        run_block(1'b1, 27'h7FFFFFF, 48'hFFFF_0000_FFFF, 0, 0);
    endtask : t_zero_len
    // hang guard, far above the few dozen cycles the blocks need
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge clock_i);
        @(negedge clock_i);
        rst_b_i = 1'b1;
        t_event_gaps();
        t_no_event();
        t_zero_len();
        print_verdict();
    end
endmodule : raw_mode_event_formatter_bench
`default_nettype wire
